// *** common/fehc_pkg.sv ***
// fehc_pkg: constants and carrier types for the parallel flash command host.
// assumes a 200 MHz core clock; all pin timing counts derive from it.
package fehc_pkg;

  localparam int CLK_PERIOD_PS = 5000;

  // pin timing in nanoseconds
  localparam int T_AS_NS = 10;     // address set-up before write strobe
  localparam int T_WP_NS = 90;     // write pulse low
  localparam int T_WPH_NS = 90;    // write pulse high
  localparam int T_ACC_NS = 90;    // address/strobe to output valid
  localparam int READ_STROBE_HIGH_MIN_NS = 150;  // read strobe high between toggle reads
  localparam int SYNC_STAGES = 2;

  // least times round up to whole cycles
  function automatic int nsToCyc(input int ns);
    nsToCyc = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  endfunction : nsToCyc

  localparam int AS_CYC = nsToCyc(T_AS_NS);
  localparam int WP_CYC = nsToCyc(T_WP_NS);
  localparam int WPH_CYC = nsToCyc(T_WPH_NS);
  // read strobe low long enough for access time plus the input synchroniser
  localparam int RD_CYC = nsToCyc(T_ACC_NS) + SYNC_STAGES + 1;
  localparam int OEHP_CYC = nsToCyc(READ_STROBE_HIGH_MIN_NS);

  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;
  localparam int TOGGLE_BIT = 6;   // position of toggle_status_bit

  // command addresses (command_address_field is 15 bits wide)
  localparam logic [14:0] CMD_ADDR = 15'h5555;
  localparam logic [14:0] UNLOCK2_ADDR = 15'h2aaa;

  // command bytes on the low data lane
  localparam logic [7:0] UNLOCK1_DATA = 8'haa;
  localparam logic [7:0] UNLOCK2_DATA = 8'h55;
  localparam logic [7:0] ERASE_SETUP_DATA = 8'h80;
  localparam logic [7:0] CHIP_ERASE_DATA = 8'h10;
  localparam logic [7:0] SECTOR_ERASE_DATA = 8'h30;
  localparam logic [7:0] LOCKOUT_DATA = 8'h40;
  localparam logic [7:0] ID_ENTRY_DATA = 8'h90;
  localparam logic [7:0] ID_EXIT_DATA = 8'hf0;

  typedef enum logic [2:0] {
    OP_READ, OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_ID_ENTRY,
    OP_ID_EXIT, OP_ID_EXIT_SHORT, OP_LOCKOUT
  } fehc_op_t;

  typedef struct packed {
    fehc_op_t op;
    logic [ADDR_W-1:0] addr;
  } fehc_req_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic [DATA_W-1:0] rdata;
  } fehc_resp_t;

  typedef struct packed {
    logic ceN;
    logic oeN;
    logic weN;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dataOut;
    logic dataOe;
  } fehc_pins_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
    logic last;
  } fehc_step_t;

endpackage : fehc_pkg

// *** rtl/fehc_host.sv ***
// fehc_host: host-side controller that issues erase, identification and lockout
// command sequences to a clockless 16-bit parallel flash and polls the toggle bit.
// assumes one request at a time on the user port and a flash wired to the pin group.
`timescale 1ns/1ps
module fehc_host (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic reqValid,
  input wire fehc_pkg::fehc_req_t req,
  output fehc_pkg::fehc_resp_t resp,
  output logic reqReady,
  output fehc_pkg::fehc_pins_t pins,
  input wire logic [fehc_pkg::DATA_W-1:0] pinDataIn
);
  import fehc_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_WSET, ST_WLOW, ST_WHIGH, ST_RLOW, ST_RHIGH
  } fehc_state_t;

  typedef struct packed {
    fehc_state_t st;
    fehc_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [2:0] idx;
    logic [7:0] cnt;
    logic poll;
    logic havePrev;
    logic prevToggle;
    logic [DATA_W-1:0] meta;
    logic [DATA_W-1:0] sync;
    fehc_resp_t resp;
    logic ready;
    fehc_pins_t pins;
  } fehc_all_t;

  fehc_all_t s_reg;
  fehc_all_t s_next;

  // command address lives in the low 15 bits; upper lines held low
  function automatic logic [ADDR_W-1:0] cmdAddr(input logic [14:0] a);
    cmdAddr = {{(ADDR_W-15){1'b0}}, a};
  endfunction : cmdAddr

  // one write of a command sequence, chosen by operation and step index
  function automatic fehc_step_t seqStep(input fehc_op_t op, input logic [2:0] idx,
                                         input logic [ADDR_W-1:0] userAddr);
    fehc_step_t s;
    logic [2:0] firstOfFinal;
    logic [2:0] fin;
    s.addr = cmdAddr(CMD_ADDR);
    s.data = 8'h00;
    s.last = 1'b0;
    // six-write forms repeat the unlock pair after the setup byte
    if (op == OP_CHIP_ERASE || op == OP_SECTOR_ERASE || op == OP_LOCKOUT) begin
      fin = 3'h5;
    end else if (op == OP_ID_EXIT_SHORT) begin
      fin = 3'h0;
    end else begin
      fin = 3'h2;
    end
    firstOfFinal = (idx >= 3'h3) ? idx - 3'h3 : idx;
    if (idx == fin) begin
      s.last = 1'b1;
      unique case (op)
        OP_CHIP_ERASE: s.data = CHIP_ERASE_DATA;
        OP_SECTOR_ERASE: begin
          s.data = SECTOR_ERASE_DATA;
          s.addr = userAddr;
        end
        OP_LOCKOUT: s.data = LOCKOUT_DATA;
        OP_ID_ENTRY: s.data = ID_ENTRY_DATA;
        OP_ID_EXIT, OP_ID_EXIT_SHORT: s.data = ID_EXIT_DATA;
        default: s.data = 8'h00;
      endcase
    end else if (firstOfFinal == 3'h0) begin
      s.addr = cmdAddr(CMD_ADDR);
      s.data = UNLOCK1_DATA;
    end else if (firstOfFinal == 3'h1) begin
      s.addr = cmdAddr(UNLOCK2_ADDR);
      s.data = UNLOCK2_DATA;
    end else begin
      s.data = ERASE_SETUP_DATA;
    end
    seqStep = s;
  endfunction : seqStep

  fehc_step_t curStep;
  logic curToggle;

  always_comb begin
    curStep = seqStep(s_reg.op, s_reg.idx, s_reg.addr);
    curToggle = s_reg.sync[TOGGLE_BIT];
  end

  // next-state logic for the whole controller
  always_comb begin
    s_next = s_reg;
    s_next.meta = pinDataIn; // pin data crosses in through two flops
    s_next.sync = s_reg.meta;
    s_next.resp.done = 1'b0;
    if (s_reg.cnt != 8'h00) begin
      s_next.cnt = s_reg.cnt - 8'h01;
    end
    unique case (s_reg.st)
      ST_IDLE: begin
        if (reqValid && s_reg.ready) begin
          s_next.ready = 1'b0;
          s_next.resp.busy = 1'b1;
          s_next.op = req.op;
          s_next.addr = req.addr;
          s_next.idx = 3'h0;
          s_next.havePrev = 1'b0;
          if (req.op == OP_READ) begin
            s_next.poll = 1'b0;
            s_next.st = ST_RLOW;
            s_next.cnt = 8'(RD_CYC - 1);
            s_next.pins.addr = req.addr;
            s_next.pins.ceN = 1'b0;
            s_next.pins.oeN = 1'b0;
          end else begin
            s_next.st = ST_WSET;
            s_next.cnt = 8'(AS_CYC - 1);
          end
        end
      end
      ST_WSET: begin
        // address, data and chip enable settle while write enable is high
        s_next.pins.addr = curStep.addr;
        s_next.pins.dataOut = {8'h00, curStep.data}; // upper byte unused
        s_next.pins.dataOe = 1'b1;
        s_next.pins.ceN = 1'b0;
        s_next.pins.oeN = 1'b1;
        if (s_reg.cnt == 8'h00) begin
          s_next.pins.weN = 1'b0;
          s_next.st = ST_WLOW;
          s_next.cnt = 8'(WP_CYC - 1);
        end
      end
      ST_WLOW: begin
        if (s_reg.cnt == 8'h00) begin
          // data stays driven through the high phase to cover hold time
          s_next.pins.weN = 1'b1;
          s_next.pins.ceN = 1'b1;
          s_next.st = ST_WHIGH;
          s_next.cnt = 8'(WPH_CYC - 1);
        end
      end
      ST_WHIGH: begin
        if (s_reg.cnt == 8'h00) begin
          s_next.pins.dataOe = 1'b0;
          if (!curStep.last) begin
            s_next.idx = s_reg.idx + 3'h1;
            s_next.st = ST_WSET;
            s_next.cnt = 8'(AS_CYC - 1);
          end else if (s_reg.op == OP_CHIP_ERASE || s_reg.op == OP_SECTOR_ERASE
                       || s_reg.op == OP_LOCKOUT) begin
            // internal operation runs; watch the toggle bit at one address
            s_next.poll = 1'b1;
            s_next.st = ST_RLOW;
            s_next.cnt = 8'(RD_CYC - 1);
            s_next.pins.addr = s_reg.addr;
            s_next.pins.ceN = 1'b0;
            s_next.pins.oeN = 1'b0;
          end else begin
            s_next.st = ST_IDLE;
            s_next.ready = 1'b1;
            s_next.resp.busy = 1'b0;
            s_next.resp.done = 1'b1;
          end
        end
      end
      ST_RLOW: begin
        if (s_reg.cnt == 8'h00) begin
          // sample after access time plus synchroniser delay, then release
          s_next.resp.rdata = s_reg.sync;
          s_next.pins.oeN = 1'b1;
          s_next.pins.ceN = 1'b1;
          s_next.st = ST_RHIGH;
          s_next.cnt = 8'(OEHP_CYC - 1);
          s_next.prevToggle = curToggle;
          s_next.havePrev = 1'b1;
        end
      end
      ST_RHIGH: begin
        if (s_reg.cnt == 8'h00) begin
          // two equal reads in a row mean the device stopped toggling
          if (!s_reg.poll || (s_reg.havePrev && s_reg.idx == 3'h7)) begin
            s_next.st = ST_IDLE;
            s_next.ready = 1'b1;
            s_next.resp.busy = 1'b0;
            s_next.resp.done = 1'b1;
          end else begin
            s_next.st = ST_RLOW;
            s_next.cnt = 8'(RD_CYC - 1);
            s_next.pins.ceN = 1'b0;
            s_next.pins.oeN = 1'b0;
          end
        end
      end
      default: s_next.st = ST_IDLE;
    endcase
    // compare against the previous read, never the absolute level
    if (s_reg.st == ST_RLOW && s_reg.cnt == 8'h00 && s_reg.poll) begin
      s_next.idx = (s_reg.havePrev && s_reg.prevToggle == curToggle) ? 3'h7 : 3'h0;
    end
  end

  // one register for all state; pins idle deselected after reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.st <= ST_IDLE;
      s_reg.op <= OP_READ;
      s_reg.ready <= 1'b1;
      s_reg.pins.ceN <= 1'b1;
      s_reg.pins.oeN <= 1'b1;
      s_reg.pins.weN <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pins = s_reg.pins;
  assign resp = s_reg.resp;
  assign reqReady = s_reg.ready;

endmodule : fehc_host

// *** bench/fehc_host_sva.sv ***
// fehc_host_sva: timing and command checks on the flash host pins.
// assumes the fehc_pkg constants; attached to fehc_host by bind.
`timescale 1ns/1ps
module fehc_host_sva (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic reqValid,
  input wire fehc_pkg::fehc_req_t req,
  input wire fehc_pkg::fehc_resp_t resp,
  input wire logic reqReady,
  input wire fehc_pkg::fehc_pins_t pins,
  input wire logic [fehc_pkg::DATA_W-1:0] pinDataIn
);
  import fehc_pkg::*;
  int hiCnt_reg;
  logic pollSeen_reg;
  logic [ADDR_W-1:0] reqAddr_reg;
  logic [ADDR_W-1:0] pollAddr_reg;
  fehc_op_t op_reg;
  logic [7:0] lastByte_reg;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // strobe-high length, poll address and request in flight; the first read primes only
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hiCnt_reg <= 0;
      pollSeen_reg <= 1'b0;
      reqAddr_reg <= '0;
      pollAddr_reg <= '0;
      op_reg <= OP_READ;
      lastByte_reg <= 8'h00;
    end else begin
      hiCnt_reg <= pins.oeN ? hiCnt_reg + 1 : 0;
      if (reqValid && reqReady) reqAddr_reg <= req.addr;
      if (reqValid && reqReady) op_reg <= req.op;
      if ($rose(pins.weN)) lastByte_reg <= pins.dataOut[7:0];
      if ($fell(pins.oeN)) pollAddr_reg <= pins.addr;
      pollSeen_reg <= resp.done ? 1'b0 : pollSeen_reg | $fell(pins.oeN);
    end
  end
  chk_oe_write_high: assert property (!pins.weN |-> pins.oeN && !pins.ceN)
    else $error("output enable low during a write");
  chk_cmd_upper: assert property (pins.dataOe |-> pins.dataOut[15:8] == 8'h00)
    else $error("upper data byte not zero");
  chk_chip_addr: assert property ($rose(pins.weN) && pins.dataOut[7:0] == CHIP_ERASE_DATA
    |-> pins.addr == ADDR_W'(CMD_ADDR)) else $error("chip erase final write address");
  chk_sector_addr: assert property ($rose(pins.weN) &&
    pins.dataOut[7:0] == SECTOR_ERASE_DATA |-> pins.addr == reqAddr_reg)
    else $error("sector erase final write address");
  chk_erase_byte: assert property (resp.done && op_reg inside {OP_CHIP_ERASE,
    OP_SECTOR_ERASE} |-> lastByte_reg == (op_reg == OP_CHIP_ERASE ? CHIP_ERASE_DATA :
    SECTOR_ERASE_DATA)) else $error("erase final byte");
  chk_oe_high_min: assert property ($fell(pins.oeN) && pollSeen_reg |->
    hiCnt_reg >= OEHP_CYC) else $error("read strobe high too short");
  chk_poll_addr: assert property ($fell(pins.oeN) && pollSeen_reg |->
    pins.addr == pollAddr_reg) else $error("poll address moved");
  chk_done_idle: assert property (resp.done |-> reqReady && !resp.busy ##1 !resp.done)
    else $error("done without idle");
endmodule : fehc_host_sva

bind fehc_host fehc_host_sva chk (.core_clk(core_clk), .rst(rst), .reqValid(reqValid),
  .req(req), .resp(resp), .reqReady(reqReady), .pins(pins), .pinDataIn(pinDataIn));

// *** bench/fehc_flash_model.sv ***
// fehc_flash_model: behavioural clockless flash that decodes command writes.
// assumes the host pin group; array reads return the low address bits.
`timescale 1ns/1ps
module fehc_flash_model #(
  parameter int BUSY_READS = 4,
  parameter logic [15:0] MAKER_ID = 16'h0042, // arbitrary value
  parameter logic [15:0] DEVICE_ID = 16'h00c3 // arbitrary value
) (
  input wire fehc_pkg::fehc_pins_t pins,
  output logic [15:0] dq
);
  import fehc_pkg::*;
  logic [22:0] h [6];
  logic idMode = 1'b0; // starts in array read, as after power-up
  logic locked = 1'b0;
  int busyLeft = 0;
  logic [15:0] last = 16'h0000;
  logic [15:0] v;
  wire rdAct = !pins.ceN && !pins.oeN;
  wire wrAct = !pins.ceN && !pins.weN; // write pulse: both enables low
  function automatic logic [22:0] cw(input logic [14:0] a, input logic [7:0] d);
    return {a, d};
  endfunction : cw
  function automatic logic un(input int k);
    return h[k] == cw(CMD_ADDR, UNLOCK1_DATA) && h[k-1] == cw(UNLOCK2_ADDR, UNLOCK2_DATA);
  endfunction : un
  // history of writes; only the low byte and low address field count
  // latched when either enable ends the pulse: the host lifts both in one step
  always @(negedge wrAct) if (pins.dataOe) begin
    for (int i = 5; i > 0; i--) h[i] = h[i-1];
    h[0] = {pins.addr[14:0], pins.dataOut[7:0]};
    if (h[0] == cw(CMD_ADDR, ID_EXIT_DATA)) idMode = 1'b0;
    if (un(2) && h[0] == cw(CMD_ADDR, ID_ENTRY_DATA)) idMode = 1'b1;
    // anything unmatched falls through untouched
    if (un(5) && h[3] == cw(CMD_ADDR, ERASE_SETUP_DATA) && un(2)) begin
      if (h[0] == cw(CMD_ADDR, LOCKOUT_DATA)) locked = 1'b1;
      if (h[0] == cw(CMD_ADDR, CHIP_ERASE_DATA) || h[0] == cw(CMD_ADDR, LOCKOUT_DATA) ||
          (h[0][7:0] == SECTOR_ERASE_DATA && !(locked && pins.addr[18:13] == '0)))
        busyLeft = BUSY_READS;
    end
  end
  // released bus shows the inverse of the last value so a stale read cannot pass
  always_comb begin
    if (busyLeft > 0) v = 16'(busyLeft[0]) << TOGGLE_BIT;
    else if (idMode && pins.addr[18:1] == '0) v = pins.addr[0] ? DEVICE_ID : MAKER_ID;
    else v = pins.addr[15:0];
    dq = rdAct ? v : ~last;
  end
  // each finished read advances the busy status
  always @(negedge rdAct) begin
    if (!$isunknown(v)) last = v;
    if (busyLeft > 0) busyLeft--;
  end
endmodule : fehc_flash_model

// *** bench/fehc_host_tb.sv ***
// fehc_host_tb: directed scenarios for the flash host against the flash model.
// assumes fehc_pkg and the model file; checker comes in by bind.
`timescale 1ns/1ps
module fehc_host_tb;
  import fehc_pkg::*;
  localparam int BUSY_READS = 4;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic reqValid = 1'b0;
  fehc_req_t req = '0;
  fehc_resp_t resp;
  logic reqReady;
  fehc_pins_t pins;
  logic [DATA_W-1:0] pinDataIn;
  logic [DATA_W-1:0] rd;
  int n_mismatch = 0;
  int n_checks = 0;
  int nRd = 0;
  always #2.5 core_clk = ~core_clk;
  always @(negedge pins.oeN) nRd++;
  fehc_host dut (.core_clk(core_clk), .rst(rst), .reqValid(reqValid), .req(req),
    .resp(resp), .reqReady(reqReady), .pins(pins), .pinDataIn(pinDataIn));
  fehc_flash_model #(.BUSY_READS(BUSY_READS)) flash (.pins(pins), .dq(pinDataIn));
  task automatic check(input string name, input logic [DATA_W-1:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  // one request, held a cycle while idle, then a bounded wait for done
  task automatic run_op(input fehc_op_t op, input logic [ADDR_W-1:0] a);
    int n;
    @(negedge core_clk);
    nRd = 0;
    req = '{op: op, addr: a};
    reqValid = 1'b1;
    @(negedge core_clk);
    reqValid = 1'b0;
    check("busy taken", 16'({resp.busy, reqReady}), 16'h0002);
    n = 0;
    while (resp.done !== 1'b1 && n < 3000) begin
      @(negedge core_clk);
      n++;
    end
    check("done", 16'(n < 3000), 16'h0001);
    check("idle at done", 16'({resp.busy, reqReady}), 16'h0001);
    rd = resp.rdata;
  endtask : run_op
  // erase-like op: reads until the status settles, last read is array data
  task automatic poll(input fehc_op_t op, input logic [ADDR_W-1:0] a, input int reads);
    run_op(op, a);
    check("poll reads", 16'(nRd), 16'(reads));
    check("poll data", rd, a[15:0]);
  endtask : poll
  task automatic t_read();
    check("idle strobes", 16'(pins.ceN & pins.oeN & pins.weN & reqReady), 16'h0001);
    run_op(OP_READ, 19'h01234);
    check("array read", rd, 16'h1234);
  endtask : t_read
  // both exit forms, codes picked by the low address bit
  task automatic t_id();
    run_op(OP_ID_ENTRY, '0);
    run_op(OP_READ, 19'h00000);
    check("maker code", rd, flash.MAKER_ID);
    run_op(OP_READ, 19'h00001);
    check("device code", rd, flash.DEVICE_ID);
    run_op(OP_ID_EXIT, '0);
    run_op(OP_READ, 19'h00001);
    check("after exit", rd, 16'h0001);
    run_op(OP_ID_ENTRY, '0);
    run_op(OP_ID_EXIT_SHORT, '0);
    run_op(OP_READ, 19'h00000);
    check("after short exit", rd, 16'h0000);
  endtask : t_id
  task automatic t_erase();
    poll(OP_CHIP_ERASE, 19'h00040, BUSY_READS + 1);
    poll(OP_SECTOR_ERASE, 19'h10040, BUSY_READS + 1);
  endtask : t_erase
  // after lockout a boot-block erase is refused and polling settles at once
  task automatic t_lock();
    poll(OP_LOCKOUT, 19'h00040, BUSY_READS + 1);
    poll(OP_SECTOR_ERASE, 19'h00040, 2);
    poll(OP_SECTOR_ERASE, 19'h12040, BUSY_READS + 1);
  endtask : t_lock
  initial begin
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    t_read();
    t_id();
    t_erase();
    t_lock();
    finish_test();
  end
  // whole run is about 15 us; a hang counts as a mismatch
  initial begin
    #200us;
    n_mismatch++;
    finish_test();
  end
endmodule : fehc_host_tb
